// file: verilog/srm_master.sv
// srm_master: request/response master for a serial register slave
// assumes a half-duplex line; user keeps the write FIFO fed during sends
// Function
// - frames hold at most 256 bytes
// - idle 3.5 characters before each frame
// - station byte first, then function code
// - frame ends with two checksum bytes
// - wide fields go high byte first
// - master starts; slave only answers
// - checksum seed ffff, reflected poly a001
// - read holding: code 3, count 1-125
// - write single: code 6, echoed reply
// - write multiple: code 16, count 1-123
module srm_master import srm_pkg::*; #(
  parameter int GAP_CYCLES = GAP_CYC,
  parameter int TMO_CYCLES = TMO_CYC,
  parameter int BAUD_DIVISOR = BAUD_DIV,
  parameter int FIFO_DEPTH = FIFO_WORDS
) (
  // clock and reset
  input logic clk_sys_i,
  input logic rst_i,
  input logic ce_i,
  // command
  input logic cmd_valid_i,
  output logic cmd_ready_o,
  input logic [7:0] cmd_station_i,
  input logic [7:0] cmd_func_i,
  input logic [15:0] cmd_addr_i,
  input logic [6:0] cmd_count_i,
  // write data words
  input logic wr_valid_i,
  output logic wr_ready_o,
  input logic [15:0] wr_data_i,
  // read data words and status
  output logic rd_valid_o,
  output logic [15:0] rd_data_o,
  output logic done_o,
  output logic err_o,
  output logic [2:0] status_o,
  // serial line
  output logic line_tx_o,
  output logic line_oe_o,
  input logic line_rx_i
);
  localparam int GW = $clog2(GAP_CYCLES + 1);
  localparam int TW = $clog2(TMO_CYCLES + 1);
  localparam logic [GW-1:0] GAP_END = GW'(GAP_CYCLES);
  localparam logic [TW-1:0] TMO_END = TW'(TMO_CYCLES);
  localparam logic [8:0] FRAME_END = 9'(MAX_FRAME);
  generate
    if (GAP_CYCLES < 1 || TMO_CYCLES < 1 || BAUD_DIVISOR < 4) begin : g_chk
      $error("srm_master timing parameters out of range");
    end
  endgenerate

  // ****************************************
  // submodules
  // ****************************************
  srm_stream_if #(.W(8)) tx_s();
  srm_stream_if #(.W(8)) rx_s();
  srm_stream_if #(.W(16)) wr_in();
  srm_stream_if #(.W(16)) wr_out();
  logic line_active;
  assign wr_in.valid = wr_valid_i;
  assign wr_in.data = wr_data_i;
  assign wr_ready_o = wr_in.ready;
  assign rx_s.ready = 1'b1;
  srm_fifo #(.W(16), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .in_s(wr_in),
    .out_s(wr_out)
  );
  srm_uart #(.DIV(BAUD_DIVISOR)) u_uart (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .tx_s(tx_s),
    .rx_s(rx_s),
    .line_rx_i(line_rx_i),
    .line_tx_o(line_tx_o),
    .line_oe_o(line_oe_o),
    .active_o(line_active)
  );

  // ****************************************
  // state
  // ****************************************
  srm_state_t state, next_state;
  logic [7:0] station, next_station, func, next_func;
  logic [15:0] addr, next_addr, crc, next_crc, rx_crc, next_rx_crc;
  logic [6:0] count, next_count;
  logic [8:0] tx_idx, next_tx_idx, rx_len, next_rx_len;
  logic [7:0] rx_d1, next_rx_d1, rx_d2, next_rx_d2, rx_hi, next_rx_hi;
  logic bad_fld, next_bad_fld, rd_valid, next_rd_valid, done, next_done;
  logic [15:0] rd_data, next_rd_data;
  logic [2:0] code, next_code;
  logic [TW-1:0] tmo, next_tmo;
  logic [GW-1:0] gap, next_gap;
  logic is_read, is_data, is_lo, tx_fire, rx_fire, at_gap, cmd_ok;
  logic [8:0] body_len, rx_exp, pidx;
  logic [7:0] hdr_byte;

  // ****************************************
  // frame shape
  // ****************************************
  // both read codes
  assign is_read = (func == FN_RD_HOLD) || (func == FN_RD_INPUT);
  assign body_len = (func == FN_WR_MANY) ? 9'h007 + {1'b0, count, 1'b0} : 9'h006;
  assign rx_exp = is_read ? 9'h005 + {1'b0, count, 1'b0} : 9'h008;
  assign is_data = ((func == FN_WR_ONE) && (tx_idx == 9'h004 || tx_idx == 9'h005)) ||
                   ((func == FN_WR_MANY) && tx_idx >= 9'h007 && tx_idx < body_len);
  assign is_lo = (func == FN_WR_ONE) ? (tx_idx == 9'h005) : !tx_idx[0];
  assign pidx = rx_len - 9'h002;
  assign at_gap = (gap == GAP_END);

  always_comb begin
    cmd_ok = cmd_station_i >= STN_MIN && cmd_station_i <= STN_MAX &&
             (cmd_func_i == FN_WR_ONE ||
              ((cmd_func_i == FN_RD_HOLD || cmd_func_i == FN_RD_INPUT) &&
               cmd_count_i != 7'h00 && cmd_count_i <= RD_MAX) ||
              (cmd_func_i == FN_WR_MANY && cmd_count_i != 7'h00 && cmd_count_i <= WR_MAX));
  end

  always_comb begin
    unique case (tx_idx)
      9'h000: hdr_byte = station;
      9'h001: hdr_byte = func;
      9'h002: hdr_byte = addr[15:8];
      9'h003: hdr_byte = addr[7:0];
      9'h004: hdr_byte = 8'h00;
      9'h005: hdr_byte = {1'b0, count};
      default: hdr_byte = {count, 1'b0}; // byte count
    endcase
  end

  always_comb begin
    if (tx_idx == body_len) begin
      tx_s.data = crc[15:8];
    end else if (tx_idx == body_len + 9'h001) begin
      tx_s.data = crc[7:0];
    end else if (is_data) begin
      tx_s.data = is_lo ? wr_out.data[7:0] : wr_out.data[15:8];
    end else begin
      tx_s.data = hdr_byte;
    end
  end

  // only send in the send phase
  assign tx_s.valid = (state == ST_SEND) && (!is_data || wr_out.valid);
  assign tx_fire = ce_i && tx_s.valid && tx_s.ready;
  assign wr_out.ready = tx_fire && is_data && is_lo;
  assign rx_fire = ce_i && rx_s.valid;

  // ****************************************
  // line idle counter
  // ****************************************
  // idle gap timing
  always_comb begin
    next_gap = line_active ? '0 : (at_gap ? gap : gap + GW'(1));
  end
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      gap <= '0;
    end else if (ce_i) begin
      gap <= next_gap;
    end
  end

  // ****************************************
  // transaction sequencer
  // ****************************************
  always_comb begin
    next_state = state;
    next_station = station;
    next_func = func;
    next_addr = addr;
    next_count = count;
    next_tx_idx = tx_idx;
    next_crc = crc;
    next_rx_crc = rx_crc;
    next_rx_len = rx_len;
    next_rx_d1 = rx_d1;
    next_rx_d2 = rx_d2;
    next_rx_hi = rx_hi;
    next_bad_fld = bad_fld;
    next_rd_valid = 1'b0;
    next_rd_data = rd_data;
    next_done = 1'b0;
    next_code = code;
    next_tmo = tmo;
    unique case (state)
      ST_IDLE: begin
        if (cmd_valid_i) begin
          next_station = cmd_station_i;
          next_func = cmd_func_i;
          next_addr = cmd_addr_i;
          next_count = cmd_count_i;
          next_crc = CRC_INIT;
          if (cmd_ok) begin
            next_state = ST_GAP;
          end else begin
            next_done = 1'b1;
            next_code = ERR_CMD;
          end
        end
      end
      ST_GAP: begin
        if (at_gap) begin
          next_state = ST_SEND;
          next_tx_idx = 9'h000;
        end
      end
      ST_SEND: begin
        if (tx_fire) begin
          next_tx_idx = tx_idx + 9'h001;
          next_crc = (tx_idx < body_len) ? srm_crc_byte(crc, tx_s.data) : crc;
          if (tx_idx == body_len + 9'h001) begin
            next_state = ST_WAIT;
            next_tmo = '0;
            next_rx_len = 9'h000;
            next_rx_crc = CRC_INIT;
            next_bad_fld = 1'b0;
          end
        end
      end
      ST_WAIT: begin
        next_tmo = tmo + TW'(1);
        if (rx_fire) begin
          next_state = ST_RECV;
        end else if (tmo == TMO_END) begin
          next_state = ST_IDLE;
          next_done = 1'b1;
          next_code = ERR_TMO;
        end
      end
      ST_RECV: begin
        // reply ends at a quiet gap
        if (at_gap) begin
          next_state = ST_IDLE;
          next_done = 1'b1;
          if (rx_len > FRAME_END) begin
            next_code = ERR_FMT;
          end else if (rx_len < 9'h004 || {rx_d2, rx_d1} != rx_crc) begin
            next_code = ERR_CRC;
          end else if (rx_len != rx_exp || bad_fld) begin
            next_code = ERR_FMT;
          end else begin
            next_code = ERR_NONE;
          end
        end
      end
      default: next_state = ST_IDLE;
    endcase
    // reply bytes pass a two-byte delay so the checksum is left out
    if (rx_fire && (state == ST_WAIT || state == ST_RECV)) begin
      next_rx_d1 = rx_s.data;
      next_rx_d2 = rx_d1;
      next_rx_len = (rx_len == 9'h1ff) ? rx_len : rx_len + 9'h001;
      if (rx_len >= 9'h002) begin
        next_rx_crc = srm_crc_byte(rx_crc, rx_d2);
        if ((pidx == 9'h000 && rx_d2 != station) || (pidx == 9'h001 && rx_d2 != func)) begin
          next_bad_fld = 1'b1;
        end
        // byte count then words, high first
        if (is_read && pidx == 9'h002 && rx_d2 != {count, 1'b0}) begin
          next_bad_fld = 1'b1;
        end
        if (is_read && pidx >= 9'h003 && pidx < rx_exp - 9'h002) begin
          if (pidx[0]) begin
            next_rx_hi = rx_d2;
          end else begin
            next_rd_valid = 1'b1;
            next_rd_data = {rx_hi, rx_d2};
          end
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      station <= 8'h00;
      func <= 8'h00;
      addr <= 16'h0000;
      count <= 7'h00;
      tx_idx <= 9'h000;
      crc <= CRC_INIT;
      rx_crc <= CRC_INIT;
      rx_len <= 9'h000;
      rx_d1 <= 8'h00;
      rx_d2 <= 8'h00;
      rx_hi <= 8'h00;
      bad_fld <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= 16'h0000;
      done <= 1'b0;
      code <= ERR_NONE;
      tmo <= '0;
    end else if (ce_i) begin
      state <= next_state;
      station <= next_station;
      func <= next_func;
      addr <= next_addr;
      count <= next_count;
      tx_idx <= next_tx_idx;
      crc <= next_crc;
      rx_crc <= next_rx_crc;
      rx_len <= next_rx_len;
      rx_d1 <= next_rx_d1;
      rx_d2 <= next_rx_d2;
      rx_hi <= next_rx_hi;
      bad_fld <= next_bad_fld;
      rd_valid <= next_rd_valid;
      rd_data <= next_rd_data;
      done <= next_done;
      code <= next_code;
      tmo <= next_tmo;
    end
  end

  // outputs
  assign cmd_ready_o = (state == ST_IDLE);
  assign rd_valid_o = rd_valid;
  assign rd_data_o = rd_data;
  assign done_o = done;
  assign status_o = code;
  assign err_o = done && (code != ERR_NONE);

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  frame_len_a: assert property (state == ST_SEND |-> tx_idx < FRAME_END)
    else $error("request frame too long");
  gap_start_a: assert property ((state == ST_SEND && $past(state) == ST_GAP) |->
    $past(gap) == GAP_END)
    else $error("frame started without idle gap");
  station_byte_a: assert property ((tx_fire && tx_idx == 9'h000) |->
    tx_s.data == station ##1 tx_idx == 9'h001)
    else $error("first byte is not the station");
  crc_low_a: assert property ((tx_fire && tx_idx == body_len + 9'h001) |->
    tx_s.data == crc[7:0] ##1 state == ST_WAIT)
    else $error("checksum tail wrong");
  crc_high_a: assert property ((tx_fire && tx_idx == body_len) |->
    tx_s.data == crc[15:8] ##1 $stable(crc))
    else $error("checksum high byte not first or checksum moved");
  quiet_send_a: assert property (state != ST_SEND |-> !tx_s.valid)
    else $error("byte offered outside send phase");
  crc_seed_a: assert property ((state == ST_SEND && tx_idx == 9'h000) |->
    crc == CRC_INIT)
    else $error("checksum not seeded");
  rd_count_a: assert property ((tx_fire && is_read && tx_idx == 9'h005) |->
    tx_s.data >= 8'h01 && tx_s.data <= {1'b0, RD_MAX})
    else $error("read count out of range");
  wr_one_a: assert property ((tx_fire && func == FN_WR_ONE && tx_idx == 9'h005) |->
    wr_out.ready)
    else $error("single write value not taken");
  wr_bytes_a: assert property ((tx_fire && func == FN_WR_MANY && tx_idx == 9'h006) |->
    tx_s.data == {count, 1'b0})
    else $error("write byte count wrong");
  read_ok_c: cover property (done && code == ERR_NONE && is_read);
  write_ok_c: cover property (done && code == ERR_NONE && func == FN_WR_MANY);
  timeout_c: cover property (done && code == ERR_TMO);
endmodule : srm_master

// file: verilog/srm_pkg.sv
// srm_pkg: constants, types and checksum step for the serial register master
// assumes a 25 MHz system clock and an 8N1 line at the default baud rate
package srm_pkg;
  // ****************************************
  // line timing
  // ****************************************
  localparam int CLK_HZ = 25_000_000;
  localparam int CLK_MHZ = CLK_HZ / 1_000_000;
  localparam int BAUD = 9600;
  localparam int BAUD_DIV = CLK_HZ / BAUD;
  localparam int GAP_US = 3650;
  localparam int GAP_CYC = GAP_US * CLK_MHZ;
  localparam int TMO_MS = 100;
  localparam int TMO_CYC = TMO_MS * (CLK_HZ / 1000);
  // ****************************************
  // frame layout and limits
  // ****************************************
  localparam int MAX_FRAME = 256;
  localparam int FIFO_WORDS = 16;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam logic [7:0] FN_RD_HOLD = 8'h03;
  localparam logic [7:0] FN_RD_INPUT = 8'h04;
  localparam logic [7:0] FN_WR_ONE = 8'h06;
  localparam logic [7:0] FN_WR_MANY = 8'h10;
  localparam logic [7:0] STN_MIN = 8'h01;
  localparam logic [7:0] STN_MAX = 8'hf7;
  localparam logic [6:0] RD_MAX = 7'h7d;
  localparam logic [6:0] WR_MAX = 7'h7b;
  localparam logic [2:0] ERR_NONE = 3'h0;
  localparam logic [2:0] ERR_CMD = 3'h1;
  localparam logic [2:0] ERR_TMO = 3'h2;
  localparam logic [2:0] ERR_CRC = 3'h3;
  localparam logic [2:0] ERR_FMT = 3'h4;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_GAP = 5'h02,
    ST_SEND = 5'h04,
    ST_WAIT = 5'h08,
    ST_RECV = 5'h10
  } srm_state_t;
  // one byte into the reflected checksum
  function automatic logic [15:0] srm_crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int j = 0; j < 8; j++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : srm_crc_byte
endpackage : srm_pkg

// file: verilog/srm_stream_if.sv
// srm_stream_if: valid/ready word stream between the master's modules
// assumes source and sink share one clock
interface srm_stream_if #(parameter int W = 8) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface : srm_stream_if

// file: verilog/srm_fifo.sv
// srm_fifo: flip-flop FIFO with valid/ready on both sides
// assumes depth is a power of two
module srm_fifo import srm_pkg::*; #(
  parameter int W = 16,
  parameter int DEPTH = FIFO_WORDS
) (
  // clock and reset
  input logic clk_sys_i,
  input logic rst_i,
  input logic ce_i,
  // streams
  srm_stream_if.snk in_s,
  srm_stream_if.src out_s
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
      $error("srm_fifo depth must be a power of two");
    end
  endgenerate
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp, next_wp, rp, next_rp;
  logic [AW:0] cnt, next_cnt;
  logic push, pop;
  // handshakes
  assign in_s.ready = (cnt != FULL);
  assign out_s.valid = (cnt != '0);
  assign out_s.data = mem[rp];
  assign push = ce_i && in_s.valid && in_s.ready;
  assign pop = ce_i && out_s.valid && out_s.ready;
  // pointer next values
  always_comb begin
    next_wp = wp + AW'(push);
    next_rp = rp + AW'(pop);
    next_cnt = cnt + (AW + 1)'(push) - (AW + 1)'(pop);
  end
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else if (ce_i) begin
      wp <= next_wp;
      rp <= next_rp;
      cnt <= next_cnt;
    end
  end
  // storage
  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem[wp] <= in_s.data;
    end
  end
endmodule : srm_fifo

// file: verilog/srm_uart.sv
// srm_uart: 8N1 byte transmitter and receiver for the shared line
// assumes the line idles high; own echo is ignored while sending
module srm_uart import srm_pkg::*; #(
  parameter int DIV = BAUD_DIV
) (
  // clock and reset
  input logic clk_sys_i,
  input logic rst_i,
  input logic ce_i,
  // byte streams
  srm_stream_if.snk tx_s,
  srm_stream_if.src rx_s,
  // line
  input logic line_rx_i,
  output logic line_tx_o,
  output logic line_oe_o,
  output logic active_o
);
  localparam int DW = $clog2(DIV);
  localparam logic [DW-1:0] DIV_LAST = DW'(DIV - 1);
  localparam logic [DW-1:0] HALF = DW'(DIV / 2);
  logic tx_busy, next_tx_busy, rx_busy, next_rx_busy, rx_vld, next_rx_vld;
  logic [DW-1:0] tx_cnt, next_tx_cnt, rx_cnt, next_rx_cnt;
  logic [3:0] tx_bit, next_tx_bit, rx_bit, next_rx_bit;
  logic [9:0] tx_sh, next_tx_sh;
  logic [7:0] rx_sh, next_rx_sh;
  logic rx_meta, rx_sync;
  assign tx_s.ready = !tx_busy;
  assign line_tx_o = tx_sh[0];
  assign line_oe_o = tx_busy;
  assign rx_s.valid = rx_vld;
  assign rx_s.data = rx_sh;
  assign active_o = tx_busy || rx_busy || !rx_sync;
  // bit timing for both directions, lsb first
  always_comb begin
    next_tx_busy = tx_busy;
    next_tx_cnt = tx_cnt + DW'(1);
    next_tx_bit = tx_bit;
    next_tx_sh = tx_sh;
    if (!tx_busy) begin
      next_tx_cnt = '0;
      if (tx_s.valid) begin
        next_tx_busy = 1'b1;
        next_tx_sh = {1'b1, tx_s.data, 1'b0};
        next_tx_bit = 4'h0;
      end
    end else if (tx_cnt == DIV_LAST) begin
      next_tx_cnt = '0;
      next_tx_sh = {1'b1, tx_sh[9:1]};
      next_tx_bit = tx_bit + 4'h1;
      next_tx_busy = (tx_bit != 4'h9);
    end
    next_rx_busy = rx_busy;
    next_rx_cnt = rx_cnt + DW'(1);
    next_rx_bit = rx_bit;
    next_rx_sh = rx_sh;
    next_rx_vld = 1'b0;
    if (!rx_busy) begin
      next_rx_cnt = HALF;
      next_rx_bit = 4'h0;
      next_rx_busy = !rx_sync && !tx_busy;
    end else if (rx_cnt == DIV_LAST) begin
      next_rx_cnt = '0;
      next_rx_bit = rx_bit + 4'h1;
      if (rx_bit == 4'h0 && rx_sync) begin
        next_rx_busy = 1'b0; // false start
      end else if (rx_bit == 4'h9) begin
        next_rx_busy = 1'b0;
        next_rx_vld = rx_sync; // good stop bit
      end else if (rx_bit != 4'h0) begin
        next_rx_sh = {rx_sync, rx_sh[7:1]};
      end
    end
  end
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      tx_busy <= 1'b0;
      tx_cnt <= '0;
      tx_bit <= 4'h0;
      tx_sh <= 10'h3ff;
      rx_busy <= 1'b0;
      rx_cnt <= '0;
      rx_bit <= 4'h0;
      rx_sh <= 8'h00;
      rx_vld <= 1'b0;
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end else if (ce_i) begin
      tx_busy <= next_tx_busy;
      tx_cnt <= next_tx_cnt;
      tx_bit <= next_tx_bit;
      tx_sh <= next_tx_sh;
      rx_busy <= next_rx_busy;
      rx_cnt <= next_rx_cnt;
      rx_bit <= next_rx_bit;
      rx_sh <= next_rx_sh;
      rx_vld <= next_rx_vld;
      rx_meta <= line_rx_i;
      rx_sync <= rx_meta;
    end
  end
endmodule : srm_uart

// file: bench/srm_slave_model.sv
// srm_slave_model: behavioural register slave on the shared serial line
// assumes the bench resolves the line with a pull-up and feeds it back here
module srm_slave_model #(
  parameter int DIV = 8,
  parameter int GAP = 280,
  parameter logic [7:0] STN = 8'h05
) (
  // clock and line
  input wire logic clk_sys_i,
  input wire logic line_i,
  input wire logic bad_i,
  output logic tx_o,
  output logic oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] fr [0:259];
  logic [15:0] mem [0:255];
  int n;
  function automatic logic [15:0] crc_of(input int len);
    logic [15:0] c;
    c = 16'hffff;
    for (int i = 0; i < len; i++) begin
      c = c ^ {8'h00, fr[i]};
      for (int j = 0; j < 8; j++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction : crc_of
  // one 8N1 character, lsb first
  task automatic put(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      tx_o <= f[i];
      repeat (DIV) @(posedge clk_sys_i);
    end
  endtask : put
  // ****************************************
  // frame service
  // ****************************************
  initial begin : serve
    logic [15:0] a;
    logic [15:0] c;
    int k;
    tx_o = 1'b1;
    oe_o = 1'b0;
    for (k = 0; k < 256; k++) mem[k] = {k[7:0] ^ 8'ha5, k[7:0]};
    forever begin
      n = 0;
      k = 0;
      while (k < GAP || n == 0) begin
        @(posedge clk_sys_i);
        k++;
        if (line_i === 1'b0) begin
          repeat (DIV / 2) @(posedge clk_sys_i);
          for (int b = 0; b < 8; b++) begin
            repeat (DIV) @(posedge clk_sys_i);
            fr[n][b] = line_i;
          end
          repeat (DIV) @(posedge clk_sys_i);
          if (n < 258) n++;
          k = 0;
        end
      end
      c = crc_of(n - 2);
      if (n >= 4 && fr[0] == STN && {fr[n-2], fr[n-1]} == c) begin
        a = {fr[2], fr[3]};
        c = {fr[4], fr[5]};
        case (fr[1])
          8'h03, 8'h04: begin
            fr[2] = {c[6:0], 1'b0};
            for (int i = 0; i < c; i++) {fr[3+2*i], fr[4+2*i]} = mem[8'(a + i)];
            n = 3 + 2 * c;
          end
          8'h06: begin
            mem[a[7:0]] = c;
            n = 6;
          end
          8'h10: begin
            for (int i = 0; i < c; i++) mem[8'(a + i)] = {fr[7+2*i], fr[8+2*i]};
            n = 6;
          end
          default: n = 0;
        endcase
        if (n > 0) begin
          c = crc_of(n) ^ {15'h0000, bad_i};
          fr[n] = c[15:8];
          fr[n+1] = c[7:0];
          oe_o <= 1'b1;
          for (int i = 0; i < n + 2; i++) put(fr[i]);
          oe_o <= 1'b0;
        end
      end
    end
  end
endmodule : srm_slave_model

// file: bench/srm_master_tb.sv
// srm_master_tb: runs each command kind against the behavioural slave
// assumes short baud, gap and timeout parameters for a quick run
module srm_master_tb import srm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DIV = 8;
  logic clk_sys_i = 0, rst_i = 1, cmd_valid_i = 0, wr_valid_i = 0, bad = 0;
  logic [7:0] cmd_station_i = 0, cmd_func_i = 0;
  logic [15:0] cmd_addr_i = 0, wr_data_i = 0, rd_data_o;
  logic [6:0] cmd_count_i = 0;
  logic [2:0] status_o, st;
  logic er;
  logic cmd_ready_o, wr_ready_o, rd_valid_o, done_o, err_o, line_tx_o, line_oe_o, m_tx, m_oe;
  wire line = m_oe ? m_tx : (line_oe_o ? line_tx_o : 1'b1);
  int fails = 0, comparisons = 0, lat;
  logic [15:0] got [$];
  // free-running system clock
  always #20 clk_sys_i = ~clk_sys_i;
  srm_master #(.GAP_CYCLES(35 * DIV), .TMO_CYCLES(3000), .BAUD_DIVISOR(DIV)) DUT (
    .clk_sys_i, .rst_i, .ce_i(1'b1), .cmd_valid_i, .cmd_ready_o, .cmd_station_i,
    .cmd_func_i, .cmd_addr_i, .cmd_count_i, .wr_valid_i, .wr_ready_o, .wr_data_i,
    .rd_valid_o, .rd_data_o, .done_o, .err_o, .status_o, .line_tx_o, .line_oe_o,
    .line_rx_i(line));
  srm_slave_model #(.DIV(DIV), .GAP(35 * DIV)) slave (
    .clk_sys_i, .line_i(line), .bad_i(bad), .tx_o(m_tx), .oe_o(m_oe));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED at %0t: word %h expected %h", $time, g, e);
    end
  endtask : chk_word
  task automatic chk_stat(input logic [2:0] g, input logic [2:0] e);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED at %0t: status %h expected %h", $time, g, e);
    end
  endtask : chk_stat
  function automatic logic [15:0] initial_word(input logic [15:0] a);
    return {a[7:0] ^ 8'ha5, a[7:0]};
  endfunction : initial_word
  // one command, collecting read words until done
  task automatic run_cmd(input logic [38:0] c);
    got.delete();
    @(posedge clk_sys_i);
    cmd_valid_i <= 1'b1;
    {cmd_station_i, cmd_func_i, cmd_addr_i, cmd_count_i} <= c;
    @(posedge clk_sys_i);
    cmd_valid_i <= 1'b0;
    for (lat = 0; lat < 40000; lat++) begin
      #1;
      if (rd_valid_o === 1'b1) got.push_back(rd_data_o);
      if (done_o === 1'b1) break;
      @(posedge clk_sys_i);
    end
    if (lat == 40000) begin
      fails++;
      $display("CHECK FAILED at %0t: command never finished", $time);
    end
    st = status_o;
    er = err_o;
  endtask : run_cmd
  task automatic push(input logic [15:0] w);
    @(posedge clk_sys_i);
    wr_valid_i <= 1'b1;
    wr_data_i <= w;
    @(posedge clk_sys_i);
    wr_valid_i <= 1'b0;
  endtask : push
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_refuse;
    logic [38:0] cmds [6] = '{{8'h00, FN_RD_HOLD, 16'h0000, 7'h01},
      {8'hf8, FN_RD_HOLD, 16'h0000, 7'h01}, {8'h05, 8'h05, 16'h0000, 7'h01},
      {8'h05, FN_RD_INPUT, 16'h0000, 7'h00}, {8'h05, FN_RD_HOLD, 16'h0000, 7'h7e},
      {8'h05, FN_WR_MANY, 16'h0000, 7'h7c}};
    for (int i = 0; i < 6; i++) begin
      run_cmd(cmds[i]);
      chk_stat(st, ERR_CMD);
      chk_word(16'(er), 16'h0001);
      chk_word(16'(lat), 16'h0000);
    end
    $display("test refuse done");
  endtask : t_refuse
  task automatic t_read;
    run_cmd({8'h05, FN_RD_HOLD, 16'h0000, 7'h7d});
    chk_stat(st, ERR_NONE);
    chk_word(16'(er), 16'h0000);
    chk_word(16'(got.size()), 16'h007d);
    for (int i = 0; i < got.size(); i++) chk_word(got[i], initial_word(16'(i)));
    run_cmd({8'h05, FN_RD_INPUT, 16'h00c8, 7'h01});
    chk_stat(st, ERR_NONE);
    chk_word(got[0], initial_word(16'h00c8));
    $display("test read done");
  endtask : t_read
  task automatic t_write;
    push(16'hbeef);
    run_cmd({8'h05, FN_WR_ONE, 16'h003f, 7'h00});
    chk_stat(st, ERR_NONE);
    for (int i = 0; i < 16; i++) push(16'hc000 + 16'(i));
    #1;
    chk_word(16'(wr_ready_o), 16'h0000);
    run_cmd({8'h05, FN_WR_MANY, 16'h0040, 7'h10});
    chk_stat(st, ERR_NONE);
    run_cmd({8'h05, FN_RD_HOLD, 16'h003f, 7'h11});
    chk_word(got[0], 16'hbeef);
    for (int i = 1; i < 17; i++) chk_word(got[i], 16'hbfff + 16'(i));
    $display("test write done");
  endtask : t_write
  task automatic t_faults;
    run_cmd({8'h09, FN_RD_HOLD, 16'h0000, 7'h01});
    chk_stat(st, ERR_TMO);
    bad <= 1'b1;
    run_cmd({8'h05, FN_RD_HOLD, 16'h0000, 7'h02});
    chk_stat(st, ERR_CRC);
    bad <= 1'b0;
    $display("test faults done");
  endtask : t_faults
  task automatic report_and_stop;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  // main sequence after a two-cycle reset
  initial begin : main
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    t_refuse();
    t_read();
    t_write();
    t_faults();
    report_and_stop();
  end
  // watchdog against a hung handshake
  initial begin : watchdog
    #3000000;
    fails++;
    report_and_stop();
  end
endmodule : srm_master_tb
